// File: src/ccc_capture_compare.sv
// device end: two capture/compare units sharing one companion timer
`timescale 1ns/1ps
// Functional notes
// RULE_01: capture copies timer into value pair
// RULE_02: mode picks falling, rising, 4th, 16th edge
// RULE_03: capture sets flag; only software clears
// RULE_04: new capture overwrites unread value
// RULE_05: three-bit select picks among eight sources
// RULE_06: pin level feeds capture even as output
// RULE_07: timer must run synchronously
// RULE_08: software masks interrupt during mode change
// RULE_09: timer clocked from instruction clock
// RULE_10: prescaler cleared when off or not capture
// RULE_11: prescaler change needs control cleared first
// RULE_12: sleep freezes internally clocked timer
// RULE_13: capture runs in sleep with external clock
// RULE_14: compare mode matches value pair against timer
// RULE_15: match toggles, sets, clears output or triggers
// RULE_16: every match sets flag; may start conversion
// RULE_17: two identical independent units
// RULE_18: zero control write clears output latch
// RULE_19: compare runs in sleep only if timer runs
// RULE_20: mode and source codes published in package
// RULE_21: sources synchronised and edge-detected once
module ccc_capture_compare #(
  parameter int UNITS = ccc_pkg::NUM_UNITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [UNITS-1:0] reg_write,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic [UNITS-1:0] flag_clear,
  input wire logic [UNITS-1:0] conv_source_sel,
  input wire logic [UNITS-1:0] mapped_pin_input,
  input wire logic [UNITS-1:0] unit_event_enable,
  output logic [UNITS*8-1:0] ctrl_rd,
  output logic [UNITS*16-1:0] value_rd,
  output logic [UNITS*3-1:0] source_rd,
  output logic [UNITS-1:0] wake_request,
  ccc_link_if.device link
);
  // capture modes are the four codes 4..7
  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m == ccc_pkg::MODE_CAP_FALL) || (m == ccc_pkg::MODE_CAP_RISE) ||
      (m == ccc_pkg::MODE_CAP_RISE4) || (m == ccc_pkg::MODE_CAP_RISE16);
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == ccc_pkg::MODE_CMP_TOGGLE) || (m == ccc_pkg::MODE_CMP_SET) ||
      (m == ccc_pkg::MODE_CMP_CLEAR) || (m == ccc_pkg::MODE_CMP_SWINT) ||
      (m == ccc_pkg::MODE_CMP_TRIG);
  endfunction

  logic [15:0] timer_now;
  assign timer_now = {link.companion_timer_high, link.companion_timer_low};

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      logic [7:0] ctrl;
      logic [2:0] src_sel;
      logic [15:0] value;
      logic [3:0] presc;
      logic flag;
      logic out_latch;
      logic trig;
      logic sync1;
      logic sync2;
      logic sync_prev;
      logic src_level;
      logic rise;
      logic fall;
      logic edge_hit;
      logic cap_now;
      logic match;
      logic match_prev;
      logic match_evt;
      logic wr_ctrl;
      logic [3:0] mode;
      logic enabled;

      assign mode = ctrl[ccc_pkg::CTRL_MODE_LSB +: 4];
      assign enabled = ctrl[ccc_pkg::CTRL_EN_BIT];
      assign wr_ctrl = reg_write[u] && (reg_sel == ccc_pkg::REG_CONTROL);

      // eight-way source select; the pin entry is the pad level so port writes count
      always_comb begin
        case (src_sel)
          ccc_pkg::SRC_PIN: src_level = mapped_pin_input[u]; // see RULE_06
          ccc_pkg::SRC_CMP1: src_level = link.event_sources[0];
          ccc_pkg::SRC_CMP2: src_level = link.event_sources[1];
          ccc_pkg::SRC_PIN_CHANGE: src_level = link.event_sources[2];
          ccc_pkg::SRC_LC1: src_level = link.event_sources[3];
          ccc_pkg::SRC_LC2: src_level = link.event_sources[4];
          ccc_pkg::SRC_LC3: src_level = link.event_sources[5];
          ccc_pkg::SRC_LC4: src_level = link.event_sources[6];
          default: src_level = 1'b0;
        endcase
      end // see RULE_05

      // two-stage synchroniser then edge detect; stage one feeds only stage two
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
          sync_prev <= 1'b0;
        end else begin
          sync1 <= src_level;
          sync2 <= sync1;
          sync_prev <= sync2; // see RULE_21
        end
      end
      assign rise = sync2 && !sync_prev;
      assign fall = !sync2 && sync_prev;

      // edge selection and prescale terminal counts
      always_comb begin
        case (mode)
          ccc_pkg::MODE_CAP_FALL: edge_hit = fall;
          ccc_pkg::MODE_CAP_RISE: edge_hit = rise;
          ccc_pkg::MODE_CAP_RISE4: edge_hit = rise;
          ccc_pkg::MODE_CAP_RISE16: edge_hit = rise;
          default: edge_hit = 1'b0;
        endcase
        if (mode == ccc_pkg::MODE_CAP_RISE4) begin
          cap_now = edge_hit && (presc[1:0] == ccc_pkg::PRESCALE_4_LAST[1:0]);
        end else if (mode == ccc_pkg::MODE_CAP_RISE16) begin
          cap_now = edge_hit && (presc == ccc_pkg::PRESCALE_16_LAST);
        end else begin
          cap_now = edge_hit;
        end
        cap_now = cap_now && enabled; // see RULE_02
      end

      // prescaler: cleared when off or out of capture; mode switches keep the count
      always_ff @(posedge clk) begin
        if (!rst_n || !enabled || !is_capture(mode)) begin
          presc <= 4'h0; // see RULE_10
        end else if (edge_hit) begin
          presc <= presc + 4'h1; // see RULE_11
        end
      end

      // compare fires once on entering equality, so a stopped timer does not repeat it
      assign match = enabled && is_compare(mode) && (value == timer_now); // see RULE_14
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          match_prev <= 1'b0;
        end else begin
          match_prev <= match;
        end
      end
      assign match_evt = match && !match_prev; // see RULE_19

      // control and source registers
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ctrl <= ccc_pkg::CTRL_RESET;
          src_sel <= ccc_pkg::CAP_SRC_RESET;
        end else if (reg_write[u]) begin
          if (reg_sel == ccc_pkg::REG_CONTROL) begin
            ctrl <= reg_wdata;
          end else if (reg_sel == ccc_pkg::REG_SOURCE) begin
            src_sel <= reg_wdata[2:0];
          end
        end
      end

      // value pair: capture overwrites without any overrun guard
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          value <= ccc_pkg::VALUE_RESET;
        end else if (cap_now) begin
          value <= timer_now; // see RULE_01, see RULE_04, see RULE_12, see RULE_13
        end else if (reg_write[u] && reg_sel == ccc_pkg::REG_VALUE_LOW) begin
          value[7:0] <= reg_wdata;
        end else if (reg_write[u] && reg_sel == ccc_pkg::REG_VALUE_HIGH) begin
          value[15:8] <= reg_wdata;
        end
      end

      // event flag: set wins over a same-cycle software clear
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          flag <= 1'b0;
        end else if (cap_now || match_evt) begin
          flag <= 1'b1; // see RULE_03, see RULE_16
        end else if (flag_clear[u]) begin
          flag <= 1'b0;
        end
      end

      // compare output latch and conversion trigger pulse
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          out_latch <= 1'b0;
          trig <= 1'b0;
        end else begin
          trig <= match_evt && conv_source_sel[u]; // see RULE_16
          if (wr_ctrl && reg_wdata == 8'h00) begin
            out_latch <= 1'b0; // see RULE_18
          end else if (match_evt) begin
            case (mode)
              ccc_pkg::MODE_CMP_TOGGLE: out_latch <= !out_latch; // see RULE_15
              ccc_pkg::MODE_CMP_SET: out_latch <= 1'b1;
              ccc_pkg::MODE_CMP_CLEAR: out_latch <= 1'b0;
              default: out_latch <= out_latch;
            endcase
          end
        end
      end

      // per-unit readback, each unit independent
      assign ctrl_rd[u*8 +: 8] = {ctrl[7:6], out_latch, ctrl[4:0]}; // see RULE_17
      assign value_rd[u*16 +: 16] = value;
      assign source_rd[u*3 +: 3] = src_sel;
      assign wake_request[u] = flag && unit_event_enable[u];
      assign link.unit_out[u] = out_latch;
      assign link.conv_trigger[u] = trig;
      assign link.unit_event_flag[u] = flag;
    end
  endgenerate
  // codes for modes and sources live in ccc_pkg (see RULE_20)
endmodule

// File: src/ccc_link_if.sv
// interface: timer and event sources on one side, the unit pair on the other
`timescale 1ns/1ps
interface ccc_link_if;
  logic timer_run;
  logic [7:0] companion_timer_high;
  logic [7:0] companion_timer_low;
  logic [7:0] event_sources;
  logic [1:0] unit_out;
  logic [1:0] conv_trigger;
  logic [1:0] unit_event_flag;
  modport device (
    input timer_run, companion_timer_high, companion_timer_low, event_sources,
    output unit_out, conv_trigger, unit_event_flag
  );
  modport source (
    output timer_run, companion_timer_high, companion_timer_low, event_sources,
    input unit_out, conv_trigger, unit_event_flag
  );
endinterface

// File: src/ccc_pkg.sv
// package: register layout, mode and source codes for the capture/compare unit
package ccc_pkg;
  // unit_control fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_FMT_BIT = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CAP_SRC_RESET = 3'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // register selects on the software port
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_VALUE_LOW = 2'h1;
  localparam logic [1:0] REG_VALUE_HIGH = 2'h2;
  localparam logic [1:0] REG_SOURCE = 2'h3;
  // unit_function_select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SWINT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  // capture_source_select codes
  localparam logic [2:0] SRC_PIN = 3'h0;
  localparam logic [2:0] SRC_CMP1 = 3'h1;
  localparam logic [2:0] SRC_CMP2 = 3'h2;
  localparam logic [2:0] SRC_PIN_CHANGE = 3'h3;
  localparam logic [2:0] SRC_LC1 = 3'h4;
  localparam logic [2:0] SRC_LC2 = 3'h5;
  localparam logic [2:0] SRC_LC3 = 3'h6;
  localparam logic [2:0] SRC_LC4 = 3'h7;
  localparam int NUM_UNITS = 2;
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
endpackage

// File: src/ccc_timer_source.sv
// other party: companion 16-bit timer and event source drive
`timescale 1ns/1ps
module ccc_timer_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep,
  input wire logic ext_clock_en,
  input wire logic ext_clock_tick,
  input wire logic [7:0] src_levels,
  input wire logic load,
  input wire logic [15:0] load_value,
  output logic [15:0] count,
  ccc_link_if.source link
);
  // timer counts on the instruction clock; ticks are synchronous (see RULE_07) (see RULE_09)
  // with the internal clock it holds in sleep, an external tick keeps it going
  logic advance;
  assign advance = ext_clock_en ? ext_clock_tick : !sleep;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (load) begin
      count <= load_value;
    end else if (advance) begin
      count <= count + 16'h0001;
    end
  end
  assign link.timer_run = advance;
  assign link.companion_timer_high = count[15:8];
  assign link.companion_timer_low = count[7:0];
  assign link.event_sources = src_levels;
endmodule

// File: tb/ccc_link_props.sv
// checker: timing properties on the link between the unit pair and the timer side
`timescale 1ns/1ps
module ccc_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] unit_out,
  input wire logic [1:0] conv_trigger,
  input wire logic [1:0] unit_event_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a trigger is one cycle wide, so one match starts one conversion
  a_trig_once_lo: assert property (conv_trigger[0] |=> !conv_trigger[0])
    else $error("unit 0 trigger longer than a cycle");
  a_trig_once_hi: assert property (conv_trigger[1] ##1 conv_trigger[1] |-> 1'b0)
    else $error("unit 1 trigger longer than a cycle");
  // the flag lands on the same edge as the trigger or the output rise
  a_trig_flag_lo: assert property (conv_trigger[0] |-> unit_event_flag[0])
    else $error("unit 0 trigger without flag");
  a_trig_flag_hi: assert property (conv_trigger[1] |-> unit_event_flag[1])
    else $error("unit 1 trigger without flag");
  a_out_rise_lo: assert property ($rose(unit_out[0]) |-> unit_event_flag[0])
    else $error("unit 0 output rose without flag");
  a_out_rise_hi: assert property ($rose(unit_out[1]) |-> unit_event_flag[1])
    else $error("unit 1 output rose without flag");
  // sync reset must leave every link output low
  a_reset_flag: assert property (disable iff (1'b0) !rst_n |=> unit_event_flag == 2'h0)
    else $error("flag not cleared by reset");
  a_reset_out: assert property ($rose(rst_n) |-> (unit_out | conv_trigger) == 2'h0)
    else $error("output or trigger high out of reset");
  cover property (conv_trigger[1]);
  cover property ($rose(unit_out[0]));
  cover property ($fell(unit_out[1]));
endmodule

// File: tb/test_ccp_capture_compare.sv
// testbench: both link ends driven from their user sides
`timescale 1ns/1ps
module test_ccp_capture_compare;
  localparam logic [1:0] r_ctl = ccc_pkg::REG_CONTROL;
  localparam logic [1:0] r_hi = ccc_pkg::REG_VALUE_HIGH;
  localparam logic [6:0] pout = 7'h45;
  logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0, load = 1'b0;
  logic [15:0] lv = 16'h0000, cnt, ctrl_rd;
  logic [7:0] src = 8'h00, wd = 8'h00;
  logic [1:0] sel = 2'h0, wr_en = 2'h0, fclr = 2'h0, csel = 2'h0, pin = 2'h0, ien = 2'h0;
  logic [31:0] value_rd;
  logic [5:0] source_rd;
  logic [1:0] wake;
  logic ext_en = 1'b0, ext_tick = 1'b0;
  logic [3:0] n, o;
  int mismatches = 0, tests_run = 0;
  logic [3:0] cmode [4] = '{ccc_pkg::MODE_CAP_FALL, ccc_pkg::MODE_CAP_RISE,
    ccc_pkg::MODE_CAP_RISE4, ccc_pkg::MODE_CAP_RISE16};
  int cnum [4] = '{1, 1, 4, 16};
  logic [3:0] pmode [7] = '{ccc_pkg::MODE_CMP_TOGGLE, ccc_pkg::MODE_CMP_TOGGLE,
    ccc_pkg::MODE_CMP_SET, ccc_pkg::MODE_CMP_CLEAR, ccc_pkg::MODE_CMP_SWINT,
    ccc_pkg::MODE_CMP_TRIG, ccc_pkg::MODE_CMP_SET};
  ccc_link_if ccc_link_if_i ();
  wire [1:0] flag = ccc_link_if_i.unit_event_flag;
  wire [1:0] trig = ccc_link_if_i.conv_trigger;
  wire [1:0] uout = ccc_link_if_i.unit_out;
  ccc_timer_source ccc_timer_source_i (.clk(clk), .rst_n(rst_n), .sleep(sleep),
    .ext_clock_en(ext_en), .ext_clock_tick(ext_tick), .src_levels(src), .load(load),
    .load_value(lv), .count(cnt), .link(ccc_link_if_i.source));
  ccc_capture_compare ccc_capture_compare_i (.clk(clk), .rst_n(rst_n), .reg_write(wr_en),
    .reg_sel(sel), .reg_wdata(wd), .flag_clear(fclr), .conv_source_sel(csel),
    .mapped_pin_input(pin), .unit_event_enable(ien), .ctrl_rd(ctrl_rd),
    .value_rd(value_rd), .source_rd(source_rd), .wake_request(wake),
    .link(ccc_link_if_i.device));
  ccc_link_props ccc_link_props_i (.clk(clk), .rst_n(rst_n), .unit_out(uout),
    .conv_trigger(trig), .unit_event_flag(flag));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // write strobe held across exactly one rising edge
  task automatic wr(input int u, input logic [1:0] r, input logic [7:0] d);
    @(negedge clk);
    wr_en[u] = 1'b1;
    sel = r;
    wd = d;
    @(negedge clk);
    wr_en = 2'h0;
  endtask
  task automatic clr(input int u);
    @(negedge clk);
    fclr[u] = 1'b1;
    @(negedge clk);
    fclr = 2'h0;
  endtask
  // load the timer, then freeze it with sleep so captured counts are exact
  task automatic freeze(input logic [15:0] v);
    @(negedge clk);
    sleep = 1'b0;
    load = 1'b1;
    lv = v;
    @(negedge clk);
    load = 1'b0;
    sleep = 1'b1;
    tick(2);
    chk("timer", cnt, v);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset, register port, capture modes, sources, compare actions
  initial begin
    tick(5);
    rst_n = 1'b1;
    chk("ctrl", ctrl_rd, 16'h0000);
    wr(1, ccc_pkg::REG_VALUE_LOW, 8'h34);
    wr(1, r_hi, 8'h12);
    wr(1, ccc_pkg::REG_SOURCE, 8'h05);
    wr(1, r_ctl, 8'h3a);
    chk("val", value_rd[31:16], 16'h1234);
    chk("src", 16'(source_rd), 16'h0028);
    chk("ctrl", ctrl_rd, 16'h1a00);
    wr(1, ccc_pkg::REG_SOURCE, 8'h00);
    for (int u = 0; u < 2; u++) begin
      for (int m = 0; m < 4; m++) begin
        freeze(16'ha5c0 + 16'(u * 4 + m));
        wr(u, r_ctl, 8'h00);
        wr(u, r_ctl, {4'h8, cmode[m]});
        clr(u);
        for (int k = 1; k <= cnum[m]; k++) begin
          pin[u] = 1'b1;
          tick(4);
          chk("flag", 16'(flag[u]), 16'(m > 0 && k == cnum[m]));
          pin[u] = 1'b0;
          tick(4);
        end
        chk("flag", 16'(flag[u]), 16'h0001);
        chk("wake", 16'(wake[u]), 16'h0000);
        chk("val", value_rd[u*16+:16], 16'ha5c0 + 16'(u * 4 + m));
      end
    end
    // each non-pin source alone must reach the capture edge detector
    wr(0, r_ctl, 8'h00);
    wr(0, r_ctl, {4'h8, ccc_pkg::MODE_CAP_RISE});
    for (int s = 1; s < 8; s++) begin
      wr(0, ccc_pkg::REG_SOURCE, 8'(s));
      clr(0);
      pin[0] = 1'b1;
      tick(4);
      pin[0] = 1'b0;
      chk("flag", 16'(flag[0]), 16'h0000);
      src[s-1] = 1'b1;
      tick(6);
      chk("flag", 16'(flag[0]), 16'h0001);
      src = 8'h00;
      tick(6);
    end
    // external ticks keep the timer, and so capture, running through sleep
    ext_en = 1'b1;
    ext_tick = 1'b1;
    tick(3);
    ext_tick = 1'b0;
    chk("timer", cnt, 16'ha5ca);
    wr(0, ccc_pkg::REG_SOURCE, 8'h00);
    clr(0);
    pin[0] = 1'b1;
    tick(4);
    pin[0] = 1'b0;
    chk("flag", 16'(flag[0]), 16'h0001);
    chk("val", value_rd[15:0], 16'ha5ca);
    ext_en = 1'b0;
    csel = 2'h3;
    ien = 2'h3;
    freeze(16'h2000);
    for (int u = 0; u < 2; u++) begin
      wr(u, r_ctl, 8'h00);
      wr(u, ccc_pkg::REG_VALUE_LOW, 8'h00);
      for (int t = 0; t < 7; t++) begin
        // the software-interrupt step runs unselected, so no conversion may start
        csel = (t == 4) ? 2'h0 : 2'h3;
        wr(u, r_ctl, {4'h8, pmode[t]});
        wr(u, r_hi, 8'h00);
        clr(u);
        wr(u, r_hi, 8'h20);
        n = 4'h0;
        o = 4'h0;
        repeat (6) begin
          @(negedge clk);
          n = n + 4'(trig[u]);
          o = o + 4'(trig[1-u]);
        end
        chk("flag", 16'(flag[u]), 16'h0001);
        chk("out", 16'(uout[u]), 16'(pout[t]));
        chk("ctrl out", 16'(ctrl_rd[u*8+5]), 16'(pout[t]));
        chk("trig", 16'(n), 16'(t != 4));
        chk("other trig", 16'(o), 16'h0000);
        chk("wake", 16'(wake[u]), 16'h0001);
      end
      wr(u, r_ctl, 8'h00);
      chk("out", 16'(uout[u]), 16'h0000);
    end
    report_and_stop();
  end
endmodule
